// File: srg_top.sv
// Supply reset stretcher, battery switchover flags and RAM chip-select guard
//
// Contract
// RULE1 - Supply below threshold asserts processor reset at once, no timer.
// RULE2 - Reset stays asserted 35ms short or 140ms long after supply recovers.
// RULE3 - Where offered, stretch time is adjustable via timebase configuration.
// RULE4 - Active-high reset is always the complement of active-low reset.
// RULE5 - Low-supply flag low while supply low, high at once on recovery.
// RULE6 - Memory source picks main above backup plus 70mV, backup at 50mV.
// RULE7 - With valid supply, gated memory select follows its input combinationally.
// RULE8 - Supply low or below backup forces gated memory select high.
// RULE9 - On battery: ignore early fail sense; fail out, reset, low flag low.
// RULE10 - On battery: ignore kick; watchdog out, reset, battery flag, select high.
// RULE11 - On battery: ignore memory select, external timebase and timebase select.
// RULE12 - Over-temperature turns main power switch off until it clears.
// RULE13 - Battery flag low on main supply, high on backup supply.
// RULE14 - Sync comparators, count stretch in timebase cycles, restart on new drop.
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
module srg_top
  import srg_pkg::*;
#(
  parameter int unsigned SHORT_CYC = SHORT_CYC_DEF,
  parameter int unsigned LONG_CYC = LONG_CYC_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic supply_comparator_low,
  input wire logic switchover_comparator_main,
  input wire logic over_temp,
  input wire logic early_fail_sense,
  input wire logic watchdog_kick_in,
  input wire logic mem_sel_in_b,
  input wire logic ext_timebase,
  input wire logic timebase_sel_b,
  output logic cpu_reset_b,
  output logic cpu_reset,
  output logic low_supply_b,
  output logic on_battery_flag,
  output logic mem_supply_main,
  output logic main_switch_on,
  output logic early_fail_out,
  output logic watchdog_expired_out_b,
  output logic mem_sel_out_b,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  logic supply_low_s;
  logic main_ok_s;
  logic over_temp_s;
  logic fail_sense_s;
  logic ext_tb_s;
  logic tb_sel_b_s;
  logic on_batt_s;
  logic ext_tb_d_q;
  logic valid_q;
  logic [1:0] ctrl_q;
  logic [EV_W-1:0] irq_stat_q;
  logic [EV_W-1:0] irq_mask_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] target;
  logic tick;
  logic reset_rel;
  logic rd_acc;
  logic wr_acc;
  logic [EV_W-1:0] live_stat;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] live_d_q;
  logic [EV_W-1:0] evt_q;
  srg_state_t state_q;
  srg_state_t state_d;

  // Supply starts low and on battery so nothing is released early
  srg_sync #(
    .W(6),
    .INIT(6'b10_0000)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in({supply_comparator_low, switchover_comparator_main, over_temp,
               early_fail_sense, ext_timebase, timebase_sel_b}),
    .sync_out({supply_low_s, main_ok_s, over_temp_s, fail_sense_s, ext_tb_s, tb_sel_b_s})
  ); // see RULE14

  // Comparator hysteresis lives in the analogue switchover stage
  assign on_batt_s = !main_ok_s; // see RULE6

  // Timebase choice; ext edges only counted when adjustable and selected
  always_comb begin
    if (ctrl_q[CTRL_ADJ_BIT] && !tb_sel_b_s) begin
      tick = ext_tb_s && !ext_tb_d_q; // see RULE3
      target = ctrl_q[CTRL_LONG_BIT] ? EXT_LONG_CLKS : EXT_SHORT_CLKS;
    end else begin
      tick = 1'b1;
      target = ctrl_q[CTRL_LONG_BIT] ? CNT_W'(LONG_CYC) : CNT_W'(SHORT_CYC); // see RULE2
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_tb_d_q <= 1'b0;
    end else if (clk_en) begin
      ext_tb_d_q <= ext_tb_s;
    end
  end

  assign reset_rel = (state_q == SRG_STRETCH) && tick && (cnt_q == target - 1'b1);

  // Battery mode also holds the sequencer, so timebase pins are ignored then
  always_comb begin
    case (state_q)
      SRG_HOLD: state_d = SRG_STRETCH;
      SRG_STRETCH: state_d = reset_rel ? SRG_RUN : SRG_STRETCH;
      SRG_RUN: state_d = SRG_RUN;
      default: state_d = SRG_HOLD;
    endcase
    if (supply_low_s || on_batt_s) begin
      state_d = SRG_HOLD; // see RULE1 RULE11
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SRG_HOLD;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // Counter restarts on every new drop
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      if (state_d != SRG_STRETCH || state_q != SRG_STRETCH) begin
        cnt_q <= '0; // see RULE14
      end else if (tick) begin
        cnt_q <= cnt_q + 1'b1; // see RULE14
      end
    end
  end

  // Reset pair and supply flags
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_reset_b <= 1'b0;
      cpu_reset <= 1'b1;
      low_supply_b <= 1'b0;
      on_battery_flag <= 1'b1;
      mem_supply_main <= 1'b0;
      valid_q <= 1'b0;
    end else if (clk_en) begin
      cpu_reset_b <= (state_d == SRG_RUN); // see RULE1 RULE2 RULE9
      cpu_reset <= (state_d != SRG_RUN); // see RULE4 RULE10
      low_supply_b <= !supply_low_s && !on_batt_s; // see RULE5 RULE9
      on_battery_flag <= on_batt_s; // see RULE13 RULE10
      mem_supply_main <= !on_batt_s; // see RULE6
      valid_q <= !supply_low_s && !on_batt_s; // see RULE8
    end
  end

  // Watchdog timing lies outside; its output idles high and the kick is unused
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_expired_out_b <= 1'b1;
      early_fail_out <= 1'b0;
      main_switch_on <= 1'b0;
    end else if (clk_en) begin
      watchdog_expired_out_b <= 1'b1; // see RULE10
      early_fail_out <= fail_sense_s && !on_batt_s; // see RULE9
      main_switch_on <= !over_temp_s; // see RULE12
    end
  end

  // Kept combinational so the RAM select sees no clock latency
  assign mem_sel_out_b = mem_sel_in_b || !valid_q; // see RULE7 RULE8 RULE11

  // Avalon slave: one wait cycle, then the access completes
  assign rd_acc = avs_read && !avs_waitrequest;
  assign wr_acc = avs_write && !avs_waitrequest;
  assign live_stat = {over_temp_s, on_batt_s, state_q == SRG_RUN, supply_low_s};
  assign ev_set = {over_temp_s && !live_d_q[EV_OVER_TEMP], 3'b000} | evt_q;

  // Rising edges of each live condition are the interrupt events
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Matches the synchroniser reset view, so no false edge follows reset
      live_d_q <= 4'h5;
      evt_q <= 4'h0;
    end else if (clk_en) begin
      live_d_q <= live_stat;
      evt_q <= live_stat & ~live_d_q & 4'h7;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en && (avs_read && avs_waitrequest)) begin
      case (avs_address)
        OFS_CTRL: avs_readdata <= {30'h0000_0000, ctrl_q};
        OFS_STATUS: avs_readdata <= {28'h000_0000, live_stat};
        OFS_IRQ_STAT: avs_readdata <= {28'h000_0000, irq_stat_q | ev_set};
        OFS_IRQ_MASK: avs_readdata <= {28'h000_0000, irq_mask_q};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end else if (clk_en && wr_acc) begin
      if (avs_address == OFS_CTRL) begin
        ctrl_q <= avs_writedata[1:0];
      end
      if (avs_address == OFS_IRQ_MASK) begin
        irq_mask_q <= avs_writedata[EV_W-1:0];
      end
    end
  end

  // Read of the status clears it; a coincident event still lands
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_q <= 4'h0;
    end else if (clk_en) begin
      if (rd_acc && avs_address == OFS_IRQ_STAT) begin
        irq_stat_q <= ev_set;
      end else begin
        irq_stat_q <= irq_stat_q | ev_set;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b || !clk_en);

  a_reset_on_low: assert property (supply_low_s |=> !cpu_reset_b) // see RULE1
    else $error("reset not asserted on low supply");
  a_reset_inverse: assert property (cpu_reset == !cpu_reset_b) // see RULE4
    else $error("reset outputs not complementary");
  a_stretch_hold: assert property ((state_q == SRG_STRETCH && !reset_rel) |=> !cpu_reset_b) // see RULE2
    else $error("reset released before stretch ended");
  a_lowflag_fast: assert property ((!supply_low_s && !on_batt_s) |=> low_supply_b) // see RULE5
    else $error("low supply flag delayed");
  a_memsel_follow: assert property (valid_q |-> mem_sel_out_b == mem_sel_in_b) // see RULE7
    else $error("memory select not following input");
  a_memsel_force: assert property (!valid_q |-> mem_sel_out_b) // see RULE8
    else $error("memory select not forced high");
  a_batt_lows: assert property (on_batt_s |=> !early_fail_out && !cpu_reset_b && !low_supply_b) // see RULE9
    else $error("battery mode low outputs wrong");
  a_batt_highs: assert property (on_batt_s |=> on_battery_flag && cpu_reset // see RULE10
    && watchdog_expired_out_b && mem_sel_out_b)
    else $error("battery mode high outputs wrong");
  a_thermal_off: assert property (over_temp_s |=> !main_switch_on) // see RULE12
    else $error("main switch on during over temperature");
  a_source_sel: assert property (main_ok_s |=> mem_supply_main && !on_battery_flag) // see RULE13
    else $error("memory source select wrong");
  a_count_restart: assert property (supply_low_s |=> cnt_q == '0 ##1 cnt_q == '0 || !supply_low_s) // see RULE14
    else $error("stretch count not restarted");

  c_release: cover property (state_q == SRG_STRETCH ##1 state_q == SRG_RUN);
  c_battery: cover property ($rose(on_batt_s));
  c_irq: cover property ($rose(irq));
endmodule

// File: srg_pkg.sv
// Constants shared by the supply reset and RAM guard block
package srg_pkg;
  // Clock
  localparam int unsigned CLK_HZ = 100_000_000;
  // Reset stretch times as printed, in ms
  localparam int unsigned T_SHORT_MS = 35;
  localparam int unsigned T_LONG_MS = 140;
  localparam int unsigned SHORT_CYC_DEF = T_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned LONG_CYC_DEF = T_LONG_MS * (CLK_HZ / 1000);
  // Stretch in external timebase clocks
  localparam logic [23:0] EXT_SHORT_CLKS = 24'h00_0200;
  localparam logic [23:0] EXT_LONG_CLKS = 24'h00_0800;
  localparam int CNT_W = 24;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h08;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h0C;

  // Control fields
  localparam int CTRL_LONG_BIT = 0;
  localparam int CTRL_ADJ_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Status and interrupt fields (same layout for status, mask)
  localparam int EV_SUPPLY_LOW = 0;
  localparam int EV_RESET_REL = 1;
  localparam int EV_ON_BATT = 2;
  localparam int EV_OVER_TEMP = 3;
  localparam int EV_W = 4;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  typedef enum logic [1:0] {
    SRG_HOLD = 2'b00,
    SRG_STRETCH = 2'b01,
    SRG_RUN = 2'b10
  } srg_state_t;
endpackage

// File: srg_sync.sv
// Two-flop synchroniser bank for comparator and pin inputs
`timescale 1ns/100ps
module srg_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= INIT;
      sync_out <= INIT;
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// File: srg_ram_model.sv
// Decoder and battery-backed RAM model on the far side of the chip-select guard
`timescale 1ns/100ps
module srg_ram_model (
  input wire logic ref_clk,
  input wire logic supply_low,
  input wire logic access_req,
  input wire logic mem_sel_out_b,
  output logic mem_sel_in_b,
  output int guarded_hits
);
  int low_cnt = 0;
  int hit_cnt = 0;
  // Decoder selects the RAM only on request; the pin idles high while access_req is low
  assign mem_sel_in_b = ~access_req;
  // Sync latency is allowed a few cycles before a select counts as a write hazard
  always @(posedge ref_clk) begin
    low_cnt <= supply_low ? low_cnt + 1 : 0;
    if (low_cnt >= 4 && mem_sel_out_b === 1'b0) hit_cnt <= hit_cnt + 1;
  end
  assign guarded_hits = hit_cnt;
endmodule

// File: srg_tb.sv
// Self-checking bench for the supply reset and RAM guard
`timescale 1ns/100ps
module testbench;
  import srg_pkg::*;
  localparam int SH = 20;
  localparam int LG = 50;
  logic ref_clk, rst_b, clk_en, sup_low, sw_main, over_temp, efs, kick, ext_timebase, tb_sel_b, access_req, tb_run;
  logic avs_read, avs_write, avs_waitrequest, irq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic cpu_reset_b, cpu_reset, low_supply_b, on_batt, mem_main, main_sw, efo, wdo_b, sel_in_b, sel_out_b;
  logic [2:0] tbc = 3'h0;
  int fail_count = 0;
  int n_compared = 0;
  int hits, nl, nr;
  srg_top #(.SHORT_CYC(SH), .LONG_CYC(LG)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
    .supply_comparator_low(sup_low), .switchover_comparator_main(sw_main), .over_temp(over_temp),
    .early_fail_sense(efs), .watchdog_kick_in(kick), .mem_sel_in_b(sel_in_b), .ext_timebase(ext_timebase),
    .timebase_sel_b(tb_sel_b), .cpu_reset_b(cpu_reset_b), .cpu_reset(cpu_reset), .low_supply_b(low_supply_b),
    .on_battery_flag(on_batt), .mem_supply_main(mem_main), .main_switch_on(main_sw), .early_fail_out(efo),
    .watchdog_expired_out_b(wdo_b), .mem_sel_out_b(sel_out_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  // Battery mode is as unsafe for the RAM as a low supply
  srg_ram_model ram (.ref_clk(ref_clk), .supply_low(sup_low | ~sw_main), .access_req(access_req),
    .mem_sel_out_b(sel_out_b), .mem_sel_in_b(sel_in_b), .guarded_hits(hits));
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  // External timebase, one rising edge every 8 clocks while enabled
  always @(posedge ref_clk) begin
    tbc <= tbc + 3'h1;
    ext_timebase <= tb_run & tbc[2];
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    // Hold the request until waitrequest is sampled low at an edge
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 100);
    if (k >= 100) fail_count++;
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task drop;
    @(posedge ref_clk);
    sup_low <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
  task recover;
    nl = -1;
    nr = 0;
    @(posedge ref_clk);
    sup_low <= 1'b0;
    while (cpu_reset_b !== 1'b1 && nr < 30000) begin
      @(posedge ref_clk);
      #1;
      nr++;
      if (nl < 0 && low_supply_b === 1'b1) nl = nr;
    end
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #800_000;
    fail_count++;
    end_sim();
  end
  initial begin
    {rst_b, sup_low, sw_main, over_temp, efs, kick, tb_sel_b, access_req, tb_run} = 9'b0_1001_0011;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    clk_en = 1'b1;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    tb_sel_b <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("cpu_reset_b", 0, cpu_reset_b);
    chk("cpu_reset", 1, cpu_reset);
    chk("early_fail_out", 0, efo);
    chk("low_supply_b", 0, low_supply_b);
    chk("wdo_b", 1, wdo_b);
    chk("mem_sel_out_b", 1, sel_out_b);
    chk("on_batt", 1, on_batt);
    bus(1, OFS_IRQ_MASK, 32'h0000_000F, rd);
    bus(0, OFS_IRQ_MASK, 0, rd);
    chk("irq mask", 32'h0000_000F, rd);
    @(posedge ref_clk);
    sw_main <= 1'b1;
    tb_sel_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("on_batt main", 0, on_batt);
    chk("mem_main", 1, mem_main);
    chk("efo main", 1, efo);
    chk("sel guarded", 1, sel_out_b);
    recover();
    chk("low flag prompt", 1, nl >= 0 && nl <= 4);
    chk("short stretch", 1, nr >= SH && nr <= SH + 8);
    chk("reset pair", {31'h0, ~cpu_reset_b}, {31'h0, cpu_reset});
    chk("sel follows", 0, sel_out_b);
    @(posedge ref_clk);
    access_req <= 1'b0;
    #1;
    chk("sel follows hi", 1, sel_out_b);
    bus(0, OFS_IRQ_STAT, 0, rd);
    chk("irq rel bit", 1, rd[EV_RESET_REL]);
    bus(0, OFS_IRQ_STAT, 0, rd);
    chk("irq cleared", 0, rd);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("irq low", 0, irq);
    drop();
    recover();
    drop();
    @(posedge ref_clk);
    sup_low <= 1'b0;
    repeat (SH / 2) @(posedge ref_clk);
    sup_low <= 1'b1;
    #1;
    chk("mid stretch", 0, cpu_reset_b);
    repeat (8) @(posedge ref_clk);
    #1;
    chk("irq set", 1, irq);
    recover();
    chk("restart stretch", 1, nr >= SH && nr <= SH + 8);
    bus(1, OFS_CTRL, 32'h0000_0001, rd);
    bus(0, OFS_CTRL, 0, rd);
    chk("ctrl", 1, rd);
    drop();
    recover();
    chk("long stretch", 1, nr >= LG && nr <= LG + 8);
    bus(1, OFS_CTRL, 32'h0000_0002, rd);
    @(posedge ref_clk);
    tb_sel_b <= 1'b0;
    tb_run <= 1'b1;
    drop();
    recover();
    chk("adj stretch", 1, nr >= EXT_SHORT_CLKS * 8 - 16 && nr <= EXT_SHORT_CLKS * 8 + 40);
    bus(1, OFS_CTRL, 32'h0000_0003, rd);
    drop();
    recover();
    chk("adj long stretch", 1, nr >= EXT_LONG_CLKS * 8 - 16 && nr <= EXT_LONG_CLKS * 8 + 40);
    bus(1, OFS_CTRL, 32'h0000_0000, rd);
    bus(1, 5'h10, 32'h0000_0003, rd);
    bus(0, 5'h10, 0, rd);
    chk("unmapped", 0, rd);
    @(posedge ref_clk);
    over_temp <= 1'b1;
    repeat (30) @(posedge ref_clk);
    #1;
    chk("switch off", 0, main_sw);
    @(posedge ref_clk);
    over_temp <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("switch on", 1, main_sw);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    over_temp <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("frozen switch", 1, main_sw);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("thawed switch", 0, main_sw);
    @(posedge ref_clk);
    over_temp <= 1'b0;
    access_req <= 1'b1;
    sw_main <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("batt reset", 0, cpu_reset_b);
    chk("batt efo", 0, efo);
    chk("batt low flag", 0, low_supply_b);
    chk("batt sel", 1, sel_out_b);
    @(posedge ref_clk);
    sw_main <= 1'b1;
    recover();
    chk("batt stretch", 1, nr >= SH && nr <= SH + 8);
    drop();
    #1;
    chk("drop reset", 0, cpu_reset_b);
    chk("guard hits", 0, hits);
    end_sim();
  end
endmodule
